// >>> core/cdpwm_ctrl.sv
// pwm mode control: routing, spread spectrum, phase sync, thermal foldback, power state, modulation
// assumes a synchronous byte register port and synchronous audio clock and sync inputs
//
// Function
// - paralleled output feeds the single amplifier from the left frame
// - spread spectrum on when 0x6B holds 0x03; 0x6C picks frequency and range
// - triangle index 0-3 is 24k, 4-7 is 48k; ranges 5,10,20,25 percent
// - bit 0 of 0x53 turns the 180 degree channel offset on and off
// - 0x6A selects one of four phases, successive ones 45 degrees apart
// - clock return after arming aligns phase with no further register action
// - pin made sync input through 0x60 and 0x64, then phase and enable set
// - play request while armed holds hiz and reports it in 0x68
// - rising sync edge moves armed device to play with phase fixed
// - four temperature thresholds reported in bits 0 to 3 of 0x73
// - warning lowers gain stepwise, more for higher levels
// - below warning the gain ramps back gradually
// - foldback amount and attack and release rates programmable
// - 0x03 bits 1:0 select deep sleep, sleep, hiz or play
// - deep sleep keeps control and dsp state; play code returns to play
// - sleep keeps control, core, memory and regulator powered
// - hiz tri-states only the output drivers
// - bits 1:0 of 0x02 select bd, single-side or hybrid modulation
// - bd: outputs in phase at zero, duty split around half
// - single-side idles near 17 percent, falling side clamps to ground
// - hybrid adjusts duty from signal level and supply
// - bit 2 of 0x02 chooses paralleled or dual bridged output
// - bits 6 to 4 of 0x02 set switching frequency
`timescale 1ns/10ps
`include "cdpwm_regs.svh"
module cdpwm_ctrl #(
  parameter int CARRIER_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire cdpwm_pkg::cdpwm_bus_t reg_bus_in,
  output logic [7:0] reg_rdata_out,
  input wire logic audio_clk_run_in,
  input wire logic sync_pin_in,
  input wire logic [3:0] temp_level_in,
  input wire logic signed [7:0] left_sample_in,
  input wire logic signed [7:0] right_sample_in,
  input wire logic [7:0] signal_level_in,
  input wire logic [7:0] supply_level_in,
  output cdpwm_pkg::cdpwm_out_t pwm_out,
  output cdpwm_pkg::cdpwm_out_t pwm_oe_out,
  output logic [2:0] fsw_sel_out,
  output logic ss_enable_out,
  output logic ss_tri_48k_out,
  output logic [1:0] ss_range_out,
  output logic [7:0] gain_out,
  output logic core_on_out,
  output logic regulator_on_out
);
  if (CARRIER_W != 8) begin : g_bad_carrier
    $error("carrier width must be 8");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] swmod;
    logic [7:0] pwrreq;
    logic [7:0] chph;
    logic [7:0] pinfn;
    logic [7:0] pinsel;
    logic [7:0] mdph;
    logic [7:0] ssen;
    logic [7:0] ssfr;
    logic [7:0] tfb_att;
    logic [7:0] tfb_rate;
    cdpwm_pkg::cdpwm_pwr_t pwr;
    logic aclk_d;
    logic sync_d;
    logic aligned;
    logic [7:0] carrier;
    logic [7:0] rate_cnt;
    logic [7:0] gain;
    logic [3:0] twarn;
    logic [7:0] rdata;
    cdpwm_pkg::cdpwm_out_t pwm;
    cdpwm_pkg::cdpwm_out_t oe;
  } cdpwm_state_t;

  cdpwm_state_t s_reg;
  cdpwm_state_t s_next;

  logic [1:0] ph_idx;
  logic sync_armed;
  logic gpio_mode;
  logic [7:0] att_target;
  logic [7:0] gain_floor;
  logic [7:0] car_a;
  logic [7:0] car_b;
  logic [7:0] duty_l;
  logic [7:0] duty_r;
  logic [7:0] pwr_code;
  logic signed [7:0] smp_b;

  assign ph_idx = s_reg.mdph[3:2];
  assign sync_armed = (s_reg.mdph[1:0] == 2'h3);
  assign gpio_mode = (s_reg.pinfn == `CDPWM_PINFN_SYNC) && (s_reg.pinsel == `CDPWM_PINSEL_SYNC);

  // higher warning levels ask for more attenuation
  always_comb begin
    att_target = 8'h00;
    if (s_reg.twarn[3]) att_target = s_reg.tfb_att;
    else if (s_reg.twarn[2]) att_target = {1'b0, s_reg.tfb_att[7:1]} + {2'b00, s_reg.tfb_att[7:2]};
    else if (s_reg.twarn[1]) att_target = {1'b0, s_reg.tfb_att[7:1]};
    else if (s_reg.twarn[0]) att_target = {2'b00, s_reg.tfb_att[7:2]};
    gain_floor = `CDPWM_GAIN_FULL - att_target;
  end

  // duty from a signed sample: half scale at zero except in single-side mode, which idles at CDPWM_DUTY_IDLE1S
  function automatic logic [7:0] cdpwm_duty(input logic signed [7:0] smp, input logic [1:0] mode,
                                            input logic [7:0] lvl, input logic [7:0] sup);
    logic [7:0] d;
    d = smp + 8'sh80;
    if (mode == 2'h1) d = (smp == 8'sh00) ? `CDPWM_DUTY_IDLE1S : d;
    if (mode == 2'h2) d = (lvl > sup) ? d : (d >> 1) + 8'h40;
    return d;
  endfunction : cdpwm_duty

  always_comb begin
    duty_l = cdpwm_duty(left_sample_in, s_reg.swmod[1:0], signal_level_in, supply_level_in);
    duty_r = s_reg.swmod[2] ? duty_l
                            : cdpwm_duty(right_sample_in, s_reg.swmod[1:0], signal_level_in, supply_level_in);
    smp_b = s_reg.swmod[2] ? left_sample_in : right_sample_in;
    car_a = s_reg.carrier + {1'b0, ph_idx, 5'h00};
    car_b = s_reg.chph[0] ? car_a + 8'h80 : car_a;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.aclk_d = audio_clk_run_in;
    s_next.sync_d = sync_pin_in;
    s_next.twarn = temp_level_in;
    if (reg_bus_in.wr) begin
      case (reg_bus_in.addr)
        `CDPWM_OFS_SWMOD: s_next.swmod = reg_bus_in.wdata;
        `CDPWM_OFS_PWRREQ: s_next.pwrreq = reg_bus_in.wdata;
        `CDPWM_OFS_CHPH: s_next.chph = reg_bus_in.wdata;
        `CDPWM_OFS_PINFN: s_next.pinfn = reg_bus_in.wdata;
        `CDPWM_OFS_PINSEL: s_next.pinsel = reg_bus_in.wdata;
        `CDPWM_OFS_MDPH: begin
          s_next.mdph = reg_bus_in.wdata;
          s_next.aligned = 1'b0;
        end
        `CDPWM_OFS_SSEN: s_next.ssen = reg_bus_in.wdata;
        `CDPWM_OFS_SSFR: s_next.ssfr = reg_bus_in.wdata;
        `CDPWM_OFS_TFB_ATT: s_next.tfb_att = reg_bus_in.wdata;
        `CDPWM_OFS_TFB_RATE: s_next.tfb_rate = reg_bus_in.wdata;
        default: ;
      endcase
    end
    // power state follows the request; an armed gpio sync holds hiz until the edge
    case (s_reg.pwrreq[1:0])
      2'h0: s_next.pwr = cdpwm_pkg::CDPWM_DEEP;
      2'h1: s_next.pwr = cdpwm_pkg::CDPWM_SLEEP;
      2'h2: s_next.pwr = cdpwm_pkg::CDPWM_HIZ;
      default: begin
        if (sync_armed && gpio_mode && !s_reg.aligned) begin
          s_next.pwr = cdpwm_pkg::CDPWM_HIZ;
          if (sync_pin_in && !s_reg.sync_d) begin
            s_next.aligned = 1'b1;
            s_next.carrier = 8'h00;
            s_next.pwr = cdpwm_pkg::CDPWM_PLAY;
          end
        end else begin
          s_next.pwr = cdpwm_pkg::CDPWM_PLAY;
        end
      end
    endcase
    // clock return after arming restarts the carrier at the common origin
    if (sync_armed && !gpio_mode && audio_clk_run_in && !s_reg.aclk_d) begin
      s_next.carrier = 8'h00;
      s_next.aligned = 1'b1;
    end else if (audio_clk_run_in) begin
      s_next.carrier = s_reg.carrier + 8'h01;
    end
    // foldback ramp: attack and release each step one count per rate period
    if (s_reg.rate_cnt == 8'h00) begin
      s_next.rate_cnt = (s_reg.gain > gain_floor) ? {4'h0, s_reg.tfb_rate[3:0]} : {4'h0, s_reg.tfb_rate[7:4]};
      if (s_reg.gain > gain_floor) s_next.gain = s_reg.gain - 8'h01;
      else if (s_reg.gain < gain_floor) s_next.gain = s_reg.gain + 8'h01;
    end else begin
      s_next.rate_cnt = s_reg.rate_cnt - 8'h01;
    end
    // register readback
    case (reg_bus_in.addr)
      `CDPWM_OFS_SWMOD: s_next.rdata = s_reg.swmod;
      `CDPWM_OFS_PWRREQ: s_next.rdata = s_reg.pwrreq;
      `CDPWM_OFS_CHPH: s_next.rdata = s_reg.chph;
      `CDPWM_OFS_PINFN: s_next.rdata = s_reg.pinfn;
      `CDPWM_OFS_PINSEL: s_next.rdata = s_reg.pinsel;
      `CDPWM_OFS_PWRST: s_next.rdata = pwr_code;
      `CDPWM_OFS_MDPH: s_next.rdata = s_reg.mdph;
      `CDPWM_OFS_SSEN: s_next.rdata = s_reg.ssen;
      `CDPWM_OFS_SSFR: s_next.rdata = s_reg.ssfr;
      `CDPWM_OFS_TWARN: s_next.rdata = {4'h0, s_reg.twarn};
      `CDPWM_OFS_TFB_ATT: s_next.rdata = s_reg.tfb_att;
      `CDPWM_OFS_TFB_RATE: s_next.rdata = s_reg.tfb_rate;
      default: s_next.rdata = 8'h00;
    endcase
    // pwm stage
    if (s_reg.swmod[1:0] == 2'h1) begin
      s_next.pwm.pos_a = (left_sample_in >= 0) ? (car_a < duty_l) : 1'b0;
      s_next.pwm.neg_a = (left_sample_in < 0) ? (car_a < (8'h00 - duty_l)) : 1'b0;
      s_next.pwm.pos_b = (smp_b >= 0) ? (car_b < duty_r) : 1'b0;
      s_next.pwm.neg_b = (smp_b < 0) ? (car_b < (8'h00 - duty_r)) : 1'b0;
    end else begin
      s_next.pwm.pos_a = car_a < duty_l;
      s_next.pwm.neg_a = car_a < (8'h00 - duty_l);
      s_next.pwm.pos_b = car_b < duty_r;
      s_next.pwm.neg_b = car_b < (8'h00 - duty_r);
    end
    s_next.oe = (s_next.pwr == cdpwm_pkg::CDPWM_PLAY) ? 4'hF : 4'h0;
  end

  always_comb begin
    case (s_reg.pwr)
      cdpwm_pkg::CDPWM_DEEP: pwr_code = 8'h00;
      cdpwm_pkg::CDPWM_SLEEP: pwr_code = 8'h01;
      cdpwm_pkg::CDPWM_HIZ: pwr_code = 8'h02;
      default: pwr_code = 8'h03;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
      s_reg.pwr <= cdpwm_pkg::CDPWM_DEEP;
      s_reg.gain <= `CDPWM_GAIN_FULL;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
      pwm_out <= '0;
      pwm_oe_out <= '0;
      fsw_sel_out <= 3'h0;
      ss_enable_out <= 1'b0;
      ss_tri_48k_out <= 1'b0;
      ss_range_out <= 2'h0;
      gain_out <= `CDPWM_GAIN_FULL;
      core_on_out <= 1'b0;
      regulator_on_out <= 1'b0;
    end else begin
      reg_rdata_out <= s_next.rdata;
      pwm_out <= s_next.pwm;
      pwm_oe_out <= s_next.oe;
      fsw_sel_out <= s_next.swmod[6:4];
      ss_enable_out <= (s_next.ssen == `CDPWM_SS_ON);
      ss_tri_48k_out <= s_next.ssfr[2];
      ss_range_out <= s_next.ssfr[1:0];
      gain_out <= s_next.gain;
      core_on_out <= (s_next.pwr != cdpwm_pkg::CDPWM_DEEP);
      regulator_on_out <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_ss_on;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (reg_bus_in.wr && reg_bus_in.addr == `CDPWM_OFS_SSEN && reg_bus_in.wdata == `CDPWM_SS_ON) |=> ss_enable_out;
  endproperty
  a_ss_on: assert property (p_ss_on) else $error("spread not enabled");
  property p_hiz_oe;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (s_reg.pwr != cdpwm_pkg::CDPWM_PLAY) |-> (pwm_oe_out == 4'h0);
  endproperty
  a_hiz_oe: assert property (p_hiz_oe) else $error("drivers on outside play");
  property p_play_oe;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (s_reg.pwr == cdpwm_pkg::CDPWM_PLAY) |-> (pwm_oe_out == 4'hF);
  endproperty
  a_play_oe: assert property (p_play_oe) else $error("drivers off in play");
  property p_deep_core;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (s_reg.pwr == cdpwm_pkg::CDPWM_DEEP) |-> !core_on_out && (pwm_oe_out == 4'h0);
  endproperty
  a_deep_core: assert property (p_deep_core) else $error("core or drivers on in deep sleep");
  property p_clk_align;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (sync_armed && !gpio_mode && audio_clk_run_in && !s_reg.aclk_d)
        |=> (s_reg.carrier == 8'h00) && s_reg.aligned;
  endproperty
  a_clk_align: assert property (p_clk_align) else $error("carrier not realigned on clock return");
  property p_ss_range;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (reg_bus_in.wr && reg_bus_in.addr == `CDPWM_OFS_SSFR)
        |=> (ss_tri_48k_out == $past(reg_bus_in.wdata[2])) && (ss_range_out == $past(reg_bus_in.wdata[1:0]));
  endproperty
  a_ss_range: assert property (p_ss_range) else $error("spread selection wrong");
  property p_gpio_hold;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (sync_armed && gpio_mode && !s_reg.aligned && s_reg.pwrreq[1:0] == 2'h3 && !sync_pin_in && !reg_bus_in.wr)
        |=> (s_reg.pwr == cdpwm_pkg::CDPWM_HIZ);
  endproperty
  a_gpio_hold: assert property (p_gpio_hold) else $error("left hiz before sync edge");
  property p_edge_play;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (sync_armed && gpio_mode && s_reg.pwrreq[1:0] == 2'h3 && $rose(sync_pin_in) && !reg_bus_in.wr)
        |=> (s_reg.pwr == cdpwm_pkg::CDPWM_PLAY);
  endproperty
  a_edge_play: assert property (p_edge_play) else $error("no play on sync edge");
  property p_twarn;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      ##1 (s_reg.twarn == $past(temp_level_in));
  endproperty
  a_twarn: assert property (p_twarn) else $error("warning flags wrong");
  property p_gain_step;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      ##1 (s_reg.gain - $past(s_reg.gain) == 8'h00 || s_reg.gain - $past(s_reg.gain) == 8'h01
           || $past(s_reg.gain) - s_reg.gain == 8'h01);
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("gain jumped");
  property p_sleep_core;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (s_reg.pwr == cdpwm_pkg::CDPWM_SLEEP) |-> core_on_out && regulator_on_out;
  endproperty
  a_sleep_core: assert property (p_sleep_core) else $error("core off in sleep");
  property p_pwr_code;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (reg_bus_in.addr == `CDPWM_OFS_PWRST && !reg_bus_in.wr && s_reg.pwr == cdpwm_pkg::CDPWM_HIZ
       && $stable(s_reg.pwr)) |=> (reg_rdata_out == 8'h02);
  endproperty
  a_pwr_code: assert property (p_pwr_code) else $error("power state readback wrong");
  c_play: cover property (@(posedge ref_clk_in) s_reg.pwr == cdpwm_pkg::CDPWM_PLAY);
  c_sync: cover property (@(posedge ref_clk_in) s_reg.aligned);
  c_fold: cover property (@(posedge ref_clk_in) s_reg.gain < `CDPWM_GAIN_FULL);
  c_hiz: cover property (@(posedge ref_clk_in) s_reg.pwr == cdpwm_pkg::CDPWM_HIZ);
  c_shift: cover property (@(posedge ref_clk_in) s_reg.chph[0] && s_reg.pwr == cdpwm_pkg::CDPWM_PLAY);
endmodule : cdpwm_ctrl

// >>> core/cdpwm_regs.svh
// register offsets, field values, reset values and duty and gain constants of the pwm mode control
// assumes byte registers reached through a decoded register port
`ifndef CDPWM_REGS_SVH
`define CDPWM_REGS_SVH
`define CDPWM_OFS_SWMOD 8'h02
`define CDPWM_OFS_PWRREQ 8'h03
`define CDPWM_OFS_CHPH 8'h53
`define CDPWM_OFS_PINFN 8'h60
`define CDPWM_OFS_PINSEL 8'h64
`define CDPWM_OFS_PWRST 8'h68
`define CDPWM_OFS_MDPH 8'h6A
`define CDPWM_OFS_SSEN 8'h6B
`define CDPWM_OFS_SSFR 8'h6C
`define CDPWM_OFS_TWARN 8'h73
`define CDPWM_OFS_TFB_ATT 8'h74
`define CDPWM_OFS_TFB_RATE 8'h75
`define CDPWM_RST_SWMOD 8'h00
`define CDPWM_RST_PWRREQ 8'h00
`define CDPWM_RST_ZERO 8'h00
`define CDPWM_SS_ON 8'h03
`define CDPWM_PINFN_SYNC 8'h01
`define CDPWM_PINSEL_SYNC 8'h01
`define CDPWM_GAIN_FULL 8'hFF
`define CDPWM_DUTY_HALF 8'h80
`define CDPWM_DUTY_IDLE1S 8'h2B
`endif

// >>> core/cdpwm_pkg.sv
// types shared by the pwm mode control
// assumes the constants header for numbers
package cdpwm_pkg;
  typedef enum logic [3:0] {
    CDPWM_DEEP = 4'h1,
    CDPWM_SLEEP = 4'h2,
    CDPWM_HIZ = 4'h4,
    CDPWM_PLAY = 4'h8
  } cdpwm_pwr_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } cdpwm_bus_t;
  typedef struct packed {
    logic pos_a;
    logic neg_a;
    logic pos_b;
    logic neg_b;
  } cdpwm_out_t;
endpackage : cdpwm_pkg

// >>> tb/cdpwm_host_model.sv
// host processor model: byte register writes and reads, sync pin and audio clock control
// assumes the register port of cdpwm_ctrl and one reference clock shared with the bench
`timescale 1ns/10ps
`include "cdpwm_regs.svh"
module cdpwm_host_model (
  input wire logic ref_clk_in,
  input wire logic [7:0] rdata_in,
  output cdpwm_pkg::cdpwm_bus_t bus_out,
  output logic sync_pin_out,
  output logic audio_clk_run_out
);
  // --------------------------------------------------
  // register access
  // --------------------------------------------------
  initial begin
    bus_out = '0;
    sync_pin_out = 1'b0;
    audio_clk_run_out = 1'b1;
  end

  // returns once the write has reached the outputs, two edges after it is taken
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    bus_out = '{addr: a, wdata: d, wr: 1'b1};
    @(posedge ref_clk_in);
    #1;
    bus_out.wr = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    bus_out.addr = a;
    repeat (2) @(posedge ref_clk_in);
    #1;
    d = rdata_in;
  endtask : read_reg

  // --------------------------------------------------
  // phase sync sequences
  // --------------------------------------------------
  task automatic gpio_arm(input logic [1:0] ph, output logic ok);
    logic [7:0] st;
    ok = 1'b0;
    write_reg(`CDPWM_OFS_PINFN, `CDPWM_PINFN_SYNC);
    write_reg(`CDPWM_OFS_PINSEL, `CDPWM_PINSEL_SYNC);
    write_reg(`CDPWM_OFS_MDPH, {4'h0, ph, 2'h3});
    write_reg(`CDPWM_OFS_PWRREQ, 8'h03);
    for (int i = 0; i < 50 && !ok; i++) begin
      read_reg(`CDPWM_OFS_PWRST, st);
      ok = (st === 8'h02);
    end
  endtask : gpio_arm

  task automatic sync_edge;
    @(posedge ref_clk_in);
    #1;
    sync_pin_out = 1'b1;
  endtask : sync_edge

  task automatic clock_arm(input logic [1:0] ph);
    audio_clk_run_out = 1'b0;
    write_reg(`CDPWM_OFS_PINFN, 8'h00);
    write_reg(`CDPWM_OFS_MDPH, {4'h0, ph, 2'h3});
    write_reg(`CDPWM_OFS_PWRREQ, 8'h02);
    audio_clk_run_out = 1'b1;
  endtask : clock_arm
endmodule : cdpwm_host_model

// >>> tb/test_class_d_pwm_mode_control.sv
// self-checking bench of the pwm mode control with a host model on the register port
// assumes cdpwm_ctrl, cdpwm_host_model and the constants header on the include path
`timescale 1ns/10ps
`include "cdpwm_regs.svh"
module test_class_d_pwm_mode_control;
  logic ref_clk_in, resetn_in, sync_pin, aclk_run, ss_en, ss_48k, core_on, reg_on, ok;
  cdpwm_pkg::cdpwm_bus_t bus;
  cdpwm_pkg::cdpwm_out_t pwm, oe;
  logic [7:0] rdata, gain, sig_lvl, sup_lvl, rd, g1;
  logic [3:0] temp;
  logic signed [7:0] left, right;
  logic [2:0] fsw;
  logic [1:0] ss_rng;
  int failures, n_checks, pa, na, d_pn, d_ab;

  cdpwm_ctrl cdpwm_ctrl_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_bus_in(bus),
    .reg_rdata_out(rdata), .audio_clk_run_in(aclk_run), .sync_pin_in(sync_pin), .temp_level_in(temp),
    .left_sample_in(left), .right_sample_in(right), .signal_level_in(sig_lvl), .supply_level_in(sup_lvl),
    .pwm_out(pwm), .pwm_oe_out(oe), .fsw_sel_out(fsw), .ss_enable_out(ss_en), .ss_tri_48k_out(ss_48k),
    .ss_range_out(ss_rng), .gain_out(gain), .core_on_out(core_on), .regulator_on_out(reg_on));
  cdpwm_host_model cdpwm_host_model_inst (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .bus_out(bus),
    .sync_pin_out(sync_pin), .audio_clk_run_out(aclk_run));

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cdpwm_host_model_inst.write_reg(a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    cdpwm_host_model_inst.read_reg(a, rd);
    check(rd, exp);
  endtask : rd_chk

  // one carrier period of 256 counts
  task automatic measure;
    {pa, na, d_pn, d_ab} = '0;
    repeat (256) begin
      @(posedge ref_clk_in);
      #1;
      pa += pwm.pos_a;
      na += pwm.neg_a;
      d_pn += (pwm.pos_a !== pwm.neg_a);
      d_ab += (pwm.pos_a !== pwm.pos_b);
    end
  endtask : measure

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic t_reset;
    check(gain, `CDPWM_GAIN_FULL);
    check({7'h00, core_on}, 8'h00);
    check({4'h0, oe}, 8'h00);
    rd_chk(`CDPWM_OFS_PWRST, 8'h00);
  endtask : t_reset

  task automatic t_power;
    for (int i = 0; i < 4; i++) begin
      wr(`CDPWM_OFS_PWRREQ, 8'(i));
      rd_chk(`CDPWM_OFS_PWRST, 8'(i));
      check({4'h0, oe}, (i == 3) ? 8'h0F : 8'h00);
      check({7'h00, core_on}, {7'h00, i != 0});
      check({7'h00, reg_on}, 8'h01);
    end
  endtask : t_power

  task automatic t_config;
    wr(`CDPWM_OFS_SWMOD, 8'h70);
    check({5'h00, fsw}, 8'h07);
    wr(`CDPWM_OFS_SWMOD, 8'h30);
    check({5'h00, fsw}, 8'h03);
    wr(`CDPWM_OFS_SSEN, 8'h01);
    check({7'h00, ss_en}, 8'h00);
    wr(`CDPWM_OFS_SSEN, `CDPWM_SS_ON);
    check({7'h00, ss_en}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(`CDPWM_OFS_SSFR, 8'(i));
      check({5'h00, ss_48k, ss_rng}, 8'(i));
    end
  endtask : t_config

  task automatic t_refused;
    temp = 4'hA;
    rd_chk(`CDPWM_OFS_TWARN, 8'h0A);
    wr(`CDPWM_OFS_TWARN, 8'hFF);
    rd_chk(`CDPWM_OFS_TWARN, 8'h0A);
    wr(`CDPWM_OFS_PWRST, 8'hFF);
    rd_chk(`CDPWM_OFS_PWRST, 8'h03);
    wr(8'h10, 8'h55);
    rd_chk(8'h10, 8'h00);
    temp = 4'h0;
  endtask : t_refused

  task automatic t_modulation;
    wr(`CDPWM_OFS_SWMOD, 8'h00);
    wr(`CDPWM_OFS_CHPH, 8'h00);
    measure();
    check({7'h00, d_pn == 0}, 8'h01);
    check({7'h00, d_ab == 0}, 8'h01);
    wr(`CDPWM_OFS_CHPH, 8'h01);
    measure();
    check({7'h00, d_ab > 0}, 8'h01);
    wr(`CDPWM_OFS_CHPH, 8'h00);
    left = 8'sh40;
    measure();
    check({6'h00, pa > 128, na < 128}, 8'h03);
    left = -8'sh40;
    measure();
    check({6'h00, pa < 128, na > 128}, 8'h03);
    left = 8'sh40;
    right = -8'sh40;
    wr(`CDPWM_OFS_SWMOD, 8'h04);
    measure();
    check({7'h00, d_ab == 0}, 8'h01);
    {left, right} = '0;
    wr(`CDPWM_OFS_SWMOD, 8'h01);
    measure();
    check({7'h00, pa >= 38 && pa <= 48}, 8'h01);
    wr(`CDPWM_OFS_SWMOD, 8'h02);
    rd_chk(`CDPWM_OFS_SWMOD, 8'h02);
    left = 8'sh40;
    measure();
    g1 = 8'(pa);
    sup_lvl = 8'h10;
    measure();
    check({7'h00, pa != int'(g1)}, 8'h01);
    sup_lvl = 8'hC0;
    left = 8'sh00;
  endtask : t_modulation

  task automatic t_thermal;
    wr(`CDPWM_OFS_TFB_ATT, 8'h40);
    wr(`CDPWM_OFS_TFB_RATE, 8'h11);
    temp = 4'h1;
    repeat (3) @(posedge ref_clk_in);
    #1;
    check({6'h00, gain < 8'hFF, gain > 8'hF0}, 8'h03);
    repeat (600) @(posedge ref_clk_in);
    #1;
    g1 = gain;
    temp = 4'hF;
    repeat (600) @(posedge ref_clk_in);
    #1;
    check({7'h00, gain < g1}, 8'h01);
    temp = 4'h0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    check({7'h00, gain < 8'hF0}, 8'h01);
    for (int i = 0; i < 1000 && gain !== 8'hFF; i++) @(posedge ref_clk_in);
    #1;
    check(gain, `CDPWM_GAIN_FULL);
  endtask : t_thermal

  task automatic t_gpio_sync;
    wr(`CDPWM_OFS_PWRREQ, 8'h02);
    cdpwm_host_model_inst.gpio_arm(2'h2, ok);
    if (!ok) begin
      failures++;
      summarize();
    end
    check({4'h0, oe}, 8'h00);
    repeat (20) @(posedge ref_clk_in);
    rd_chk(`CDPWM_OFS_PWRST, 8'h02);
    cdpwm_host_model_inst.sync_edge();
    repeat (3) @(posedge ref_clk_in);
    #1;
    check({4'h0, oe}, 8'h0F);
    rd_chk(`CDPWM_OFS_PWRST, 8'h03);
    rd_chk(`CDPWM_OFS_MDPH, 8'h0B);
  endtask : t_gpio_sync

  task automatic t_clock_sync;
    wr(`CDPWM_OFS_SWMOD, 8'h00);
    cdpwm_host_model_inst.clock_arm(2'h1);
    // carrier restarts on the edge after the clocks return; phase 1 leads by one 45 degree step
    repeat (2) @(posedge ref_clk_in);
    #1;
    pa = 0;
    for (int i = 0; i < 256 && pwm.pos_a === 1'b1; i++) begin
      pa++;
      @(posedge ref_clk_in);
      #1;
    end
    check(8'(pa), 8'h60);
    rd_chk(`CDPWM_OFS_PWRST, 8'h02);
    rd_chk(`CDPWM_OFS_MDPH, 8'h07);
  endtask : t_clock_sync

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    {failures, n_checks} = '0;
    resetn_in = 1'b0;
    temp = 4'h0;
    {left, right} = '0;
    sig_lvl = 8'h20;
    sup_lvl = 8'hC0;
    repeat (10) @(posedge ref_clk_in);
    #1;
    resetn_in = 1'b1;
    t_reset();
    t_power();
    t_config();
    t_refused();
    t_modulation();
    t_thermal();
    t_gpio_sync();
    t_clock_sync();
    summarize();
  end
endmodule : test_class_d_pwm_mode_control
